//--- common/dqic_regs.svh
// Register offsets, field positions and reset values of the acquisition control block
// Overview of operation
// - User counter fully programmable, six modes
// - Internal clock generator or external event counter
// - Counter value readable anytime, undisturbed
// - Stop loads one-shot zero, output high
// - Two independent interrupt lines, separate selects
// - First select: off, end-of-conversion, half-full
// - Second select: off, pacer tick, external
// - Request held until its clear; no repeat
// - Pending state of both lines readable
// - Half-full means one 512-word block stored
// - Full FIFO is overrun; samples lost
// - Samples readable via 16-bit and 32-bit words
// - 16-bit word: bit 0 LSB, bit 15 MSB
// - Software trigger starts one conversion, busy shown
// - Two chained dividers make pacer clock
// - 32-bit word: result low, channel 16..20
// - Status shows empty, half, full, busy
// - Zero in either divider stops pacer
`ifndef DQIC_REGS_SVH
`define DQIC_REGS_SVH

`define DQIC_OFF_RES16 8'h00
`define DQIC_OFF_RES32 8'h04
`define DQIC_OFF_ADSTAT 8'h08
`define DQIC_OFF_ADCTRL 8'h0C
`define DQIC_OFF_IRQSEL 8'h10
`define DQIC_OFF_IRQSTAT 8'h14
`define DQIC_OFF_IRQMASK 8'h18
`define DQIC_OFF_CNT0CTRL 8'h1C
`define DQIC_OFF_CNT0VAL 8'h20
`define DQIC_OFF_PACER1 8'h24
`define DQIC_OFF_PACER2 8'h28

`define DQIC_ST_EMPTY 0
`define DQIC_ST_HALF 1
`define DQIC_ST_FULL 2
`define DQIC_ST_BUSY 3
`define DQIC_CTL_PACER 0
`define DQIC_CTL_SOFT_TRIG 1
`define DQIC_CTL_FIFO_CLR 2
`define DQIC_SEL_FIRST_LSB 0
`define DQIC_SEL_SECOND_LSB 4
`define DQIC_IRQ_FIRST 0
`define DQIC_IRQ_SECOND 1
`define DQIC_IRQ_OVERRUN 2
`define DQIC_C0_EXT 3
`define DQIC_C0_STOP 4

`define DQIC_FIFO_DEPTH 1024
`define DQIC_FIFO_BLOCK 512
`define DQIC_RST_IRQMASK 3'h0
`define DQIC_RST_COUNT 16'h0000

`endif

//--- common/dqic_pkg.sv
// Types shared by the acquisition control block
package dqic_pkg;
  typedef logic [7:0] dqic_addr_t;
  typedef logic [15:0] dqic_count_t;
  typedef enum logic [2:0] {
    COUNTER_OP_MODE_ZERO, COUNTER_OP_MODE_ONE, COUNTER_OP_MODE_TWO,
    COUNTER_OP_MODE_THREE, COUNTER_OP_MODE_FOUR, COUNTER_OP_MODE_FIVE
  } dqic_cnt_mode_e;
  typedef enum logic [1:0] {SRC_OFF, SRC_PRIMARY, SRC_SECONDARY} dqic_irq_src_e;
  typedef struct packed {
    logic [4:0] chan;
    logic [15:0] data;
  } dqic_sample_s;

  // Codes 6 and 7 are not modes; fall back to mode zero
  function automatic dqic_cnt_mode_e dqic_to_mode(input logic [2:0] code);
    dqic_to_mode = (code > 3'h5) ? COUNTER_OP_MODE_ZERO : dqic_cnt_mode_e'(code);
  endfunction : dqic_to_mode
endpackage : dqic_pkg

//--- common/dqic_tmr_if.sv
// Control and status bundle between the register logic and one interval counter
interface dqic_tmr_if;
  logic load;
  dqic_pkg::dqic_count_t load_val;
  dqic_pkg::dqic_cnt_mode_e mode;
  logic tick;
  dqic_pkg::dqic_count_t count;
  logic out;
  logic term;
  modport ctl (output load, load_val, mode, tick, input count, out, term);
  modport tmr (input load, load_val, mode, tick, output count, out, term);
endinterface : dqic_tmr_if

//--- src/dqic_counter.sv
// Sixteen-bit interval counter with six operating modes, gate always open
`include "dqic_regs.svh"
module dqic_counter (
  input wire logic i_clk,
  input wire logic i_rst,
  dqic_tmr_if.tmr tif
);
  import dqic_pkg::*;

  dqic_count_t cnt_q;
  dqic_count_t reload_q;
  dqic_cnt_mode_e mode_q;
  logic armed_q;
  logic out_q;
  logic term_q;

  // Terminal decodes
  wire at_one = (cnt_q == 16'h0001);
  wire at_two_or_less = (cnt_q <= 16'h0002);
  wire load_low = (tif.mode == COUNTER_OP_MODE_ZERO) || (tif.mode == COUNTER_OP_MODE_ONE);

  // A zero load leaves the counter disarmed with output high; this is the stop state
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      cnt_q <= `DQIC_RST_COUNT;
      reload_q <= `DQIC_RST_COUNT;
      mode_q <= COUNTER_OP_MODE_ZERO;
      armed_q <= 1'b0;
      out_q <= 1'b1;
      term_q <= 1'b0;
    end else begin
      term_q <= 1'b0;
      if (tif.load) begin
        cnt_q <= tif.load_val;
        reload_q <= tif.load_val;
        mode_q <= tif.mode;
        armed_q <= (tif.load_val != 16'h0000);
        out_q <= (tif.load_val == 16'h0000) || !load_low;
      end else if (tif.tick && armed_q) begin
        case (mode_q)
          COUNTER_OP_MODE_ZERO, COUNTER_OP_MODE_ONE: begin
            if (at_one) begin
              cnt_q <= 16'h0000;
              out_q <= 1'b1;
              armed_q <= 1'b0;
              term_q <= 1'b1;
            end else begin
              cnt_q <= cnt_q - 16'h0001;
            end
          end
          COUNTER_OP_MODE_TWO: begin
            if (at_one) begin
              cnt_q <= reload_q;
              out_q <= 1'b1;
              term_q <= 1'b1;
            end else begin
              cnt_q <= cnt_q - 16'h0001;
              out_q <= (cnt_q != 16'h0002);
            end
          end
          COUNTER_OP_MODE_THREE: begin
            // Counts by two so each half period is half the reload ticks, rounded up
            if (at_two_or_less) begin
              cnt_q <= reload_q;
              out_q <= !out_q;
              term_q <= 1'b1;
            end else begin
              cnt_q <= cnt_q - 16'h0002;
            end
          end
          COUNTER_OP_MODE_FOUR, COUNTER_OP_MODE_FIVE: begin
            if (at_one) begin
              cnt_q <= 16'h0000;
              out_q <= 1'b0;
              armed_q <= 1'b0;
              term_q <= 1'b1;
            end else begin
              cnt_q <= cnt_q - 16'h0001;
            end
          end
          default: begin
            armed_q <= 1'b0;
          end
        endcase
      end else if (!armed_q) begin
        out_q <= 1'b1; // Strobe lasts one clock, then output rests high
      end
    end
  end

  assign tif.count = cnt_q;
  assign tif.out = out_q;
  assign tif.term = term_q;
endmodule : dqic_counter

//--- src/dqic_top.sv
// Acquisition control: APB registers, sample FIFO, trigger, counters and interrupt lines
`include "dqic_regs.svh"

module dqic_top #(
  parameter int FIFO_DEPTH = `DQIC_FIFO_DEPTH,
  parameter int FIFO_BLOCK = `DQIC_FIFO_BLOCK
) (
  input wire logic I_SYS_CLK,
  input wire logic I_RST,
  input wire logic I_PSEL,
  input wire logic I_PENABLE,
  input wire logic I_PWRITE,
  input wire dqic_pkg::dqic_addr_t I_PADDR,
  input wire logic [31:0] I_PWDATA,
  output logic [31:0] O_PRDATA,
  output logic O_PREADY,
  output logic O_PSLVERR,
  input wire logic I_CONV_DONE,
  input wire logic [15:0] I_CONV_DATA,
  input wire logic [4:0] I_CONV_CH,
  output logic O_CONV_START,
  input wire logic I_EXT_CLK,
  input wire logic I_EXT_IRQ,
  output logic O_CNT0_OUT,
  output logic O_PACER_TICK,
  output logic O_FIRST_IRQ_LINE,
  output logic O_SECOND_IRQ_LINE,
  output logic O_IRQ
);
  import dqic_pkg::*;

  localparam int AW = $clog2(FIFO_DEPTH);
  localparam int SW = 24;

  // Pin synchronisers: {done, ext clock, ext irq, channel, data}
  logic [SW-1:0] pin_s1_q;
  logic [SW-1:0] pin_s2_q;
  logic [2:0] edge_prev_q;

  // Register state
  logic [31:0] prdata_q;
  logic pacer_mode_q;
  dqic_irq_src_e first_irq_source_select_q;
  dqic_irq_src_e second_irq_source_select_q;
  logic [2:0] irq_status_q;
  logic [2:0] irq_mask_q;
  dqic_cnt_mode_e cnt0_mode_q;
  logic cnt0_ext_q;
  logic conv_start_q;
  logic conversion_busy_flag_q;
  logic half_prev_q;

  // Sample FIFO storage
  dqic_sample_s fifo_mem [FIFO_DEPTH];
  logic [AW-1:0] wr_ptr_q;
  logic [AW-1:0] rd_ptr_q;
  logic [AW:0] fill_q;

  dqic_tmr_if cnt0_if ();
  dqic_tmr_if div1_if ();
  dqic_tmr_if div2_if ();

  // Synchronised pin views; first stage feeds only the second
  wire done_s = pin_s2_q[23];
  wire ext_clk_s = pin_s2_q[22];
  wire ext_irq_s = pin_s2_q[21];
  dqic_sample_s pin_sample;
  assign pin_sample = dqic_sample_s'(pin_s2_q[20:0]);
  wire done_rise = done_s && !edge_prev_q[2];
  wire ext_clk_rise = ext_clk_s && !edge_prev_q[1];
  wire ext_irq_rise = ext_irq_s && !edge_prev_q[0];

  always_ff @(posedge I_SYS_CLK or posedge I_RST) begin
    if (I_RST) begin
      pin_s1_q <= '0;
      pin_s2_q <= '0;
      edge_prev_q <= 3'h0;
    end else begin
      pin_s1_q <= {I_CONV_DONE, I_EXT_CLK, I_EXT_IRQ, I_CONV_CH, I_CONV_DATA};
      pin_s2_q <= pin_s1_q;
      edge_prev_q <= pin_s2_q[23:21];
    end
  end

  // APB phase decode; no wait states, and read data comes from a flop captured in setup
  wire setup_ph = I_PSEL && !I_PENABLE;
  wire access_ph = I_PSEL && I_PENABLE;
  wire wr_acc = access_ph && I_PWRITE;
  wire rd_acc = access_ph && !I_PWRITE;
  wire hit_res16 = (I_PADDR == `DQIC_OFF_RES16);
  wire hit_res32 = (I_PADDR == `DQIC_OFF_RES32);
  wire hit_adstat = (I_PADDR == `DQIC_OFF_ADSTAT);
  wire hit_adctrl = (I_PADDR == `DQIC_OFF_ADCTRL);
  wire hit_irqsel = (I_PADDR == `DQIC_OFF_IRQSEL);
  wire hit_irqstat = (I_PADDR == `DQIC_OFF_IRQSTAT);
  wire hit_irqmask = (I_PADDR == `DQIC_OFF_IRQMASK);
  wire hit_c0ctrl = (I_PADDR == `DQIC_OFF_CNT0CTRL);
  wire hit_c0val = (I_PADDR == `DQIC_OFF_CNT0VAL);
  wire hit_pacer1 = (I_PADDR == `DQIC_OFF_PACER1);
  wire hit_pacer2 = (I_PADDR == `DQIC_OFF_PACER2);
  wire hit_any = hit_res16 || hit_res32 || hit_adstat || hit_adctrl || hit_irqsel ||
                 hit_irqstat || hit_irqmask || hit_c0ctrl || hit_c0val || hit_pacer1 ||
                 hit_pacer2;

  assign O_PREADY = access_ph;
  assign O_PSLVERR = access_ph && !hit_any;
  assign O_PRDATA = prdata_q;

  // FIFO flags
  wire fifo_empty_flag = (fill_q == '0);
  wire fifo_full_flag = (fill_q == (AW+1)'(FIFO_DEPTH));
  wire fifo_half_full_flag = (fill_q >= (AW+1)'(FIFO_BLOCK));
  wire fifo_clr = wr_acc && hit_adctrl && I_PWDATA[`DQIC_CTL_FIFO_CLR];
  wire fifo_push = done_rise && !fifo_full_flag;
  wire fifo_overrun = done_rise && fifo_full_flag;
  wire fifo_pop = rd_acc && (hit_res16 || hit_res32) && !fifo_empty_flag;
  dqic_sample_s fifo_head;
  assign fifo_head = fifo_mem[rd_ptr_q];
  wire half_rise = fifo_half_full_flag && !half_prev_q;

  // FIFO pointers; a clear wins over a push or pop in the same cycle
  always_ff @(posedge I_SYS_CLK or posedge I_RST) begin
    if (I_RST) begin
      wr_ptr_q <= '0;
      rd_ptr_q <= '0;
      fill_q <= '0;
      half_prev_q <= 1'b0;
    end else begin
      half_prev_q <= fifo_half_full_flag;
      if (fifo_clr) begin
        wr_ptr_q <= '0;
        rd_ptr_q <= '0;
        fill_q <= '0;
      end else begin
        wr_ptr_q <= fifo_push ? wr_ptr_q + 1'b1 : wr_ptr_q;
        rd_ptr_q <= fifo_pop ? rd_ptr_q + 1'b1 : rd_ptr_q;
        fill_q <= fill_q + (AW+1)'(fifo_push) - (AW+1)'(fifo_pop);
      end
    end
  end

  // Sample storage has no reset; reading an empty FIFO returns the stale word at the read pointer
  always_ff @(posedge I_SYS_CLK) begin
    if (fifo_push) begin
      fifo_mem[wr_ptr_q] <= pin_sample;
    end
  end

  // Conversion trigger: software strobe or pacer tick, ignored while busy
  wire soft_trig = wr_acc && hit_adctrl && I_PWDATA[`DQIC_CTL_SOFT_TRIG] && !pacer_mode_q;
  wire conv_trig = pacer_mode_q ? O_PACER_TICK : soft_trig;
  wire conv_go = conv_trig && !conversion_busy_flag_q;

  always_ff @(posedge I_SYS_CLK or posedge I_RST) begin
    if (I_RST) begin
      conv_start_q <= 1'b0;
      conversion_busy_flag_q <= 1'b0;
    end else begin
      conv_start_q <= conv_go;
      if (conv_go) begin
        conversion_busy_flag_q <= 1'b1;
      end else if (done_rise) begin
        conversion_busy_flag_q <= 1'b0;
      end
    end
  end
  assign O_CONV_START = conv_start_q;

  // Counter control: counter 0 from bus, dividers chained for the pacer
  wire c0_stop = wr_acc && hit_c0ctrl && I_PWDATA[`DQIC_C0_STOP];
  assign cnt0_if.load = (wr_acc && hit_c0val) || c0_stop;
  assign cnt0_if.load_val = c0_stop ? 16'h0000 : I_PWDATA[15:0];
  assign cnt0_if.mode = c0_stop ? COUNTER_OP_MODE_ONE : cnt0_mode_q;
  assign cnt0_if.tick = cnt0_ext_q ? ext_clk_rise : 1'b1;
  assign div1_if.load = wr_acc && hit_pacer1;
  assign div1_if.load_val = I_PWDATA[15:0];
  assign div1_if.mode = COUNTER_OP_MODE_TWO;
  assign div1_if.tick = 1'b1;
  assign div2_if.load = wr_acc && hit_pacer2;
  assign div2_if.load_val = I_PWDATA[15:0];
  assign div2_if.mode = COUNTER_OP_MODE_TWO;
  assign div2_if.tick = div1_if.term;
  assign O_PACER_TICK = div2_if.term;
  assign O_CNT0_OUT = cnt0_if.out;

  dqic_counter u_cnt0 (
    .i_clk(I_SYS_CLK),
    .i_rst(I_RST),
    .tif(cnt0_if.tmr)
  );

  dqic_counter u_div1 (
    .i_clk(I_SYS_CLK),
    .i_rst(I_RST),
    .tif(div1_if.tmr)
  );

  dqic_counter u_div2 (
    .i_clk(I_SYS_CLK),
    .i_rst(I_RST),
    .tif(div2_if.tmr)
  );

  // Interrupt source decode per line
  wire first_event = ((first_irq_source_select_q == SRC_PRIMARY) && done_rise) ||
                     ((first_irq_source_select_q == SRC_SECONDARY) && half_rise);
  wire second_event = ((second_irq_source_select_q == SRC_PRIMARY) && O_PACER_TICK) ||
                      ((second_irq_source_select_q == SRC_SECONDARY) && ext_irq_rise);
  wire [2:0] irq_set = {fifo_overrun, second_event, first_event};
  wire [2:0] irq_clr = (wr_acc && hit_irqstat) ? I_PWDATA[2:0] : 3'h0;

  // Control registers written over the bus
  always_ff @(posedge I_SYS_CLK or posedge I_RST) begin
    if (I_RST) begin
      pacer_mode_q <= 1'b0;
      first_irq_source_select_q <= SRC_OFF;
      second_irq_source_select_q <= SRC_OFF;
      irq_mask_q <= `DQIC_RST_IRQMASK;
      cnt0_mode_q <= COUNTER_OP_MODE_ZERO;
      cnt0_ext_q <= 1'b0;
    end else if (wr_acc) begin
      if (hit_adctrl) begin
        pacer_mode_q <= I_PWDATA[`DQIC_CTL_PACER];
      end
      if (hit_irqsel) begin
        first_irq_source_select_q <= dqic_irq_src_e'(I_PWDATA[`DQIC_SEL_FIRST_LSB +: 2]);
        second_irq_source_select_q <= dqic_irq_src_e'(I_PWDATA[`DQIC_SEL_SECOND_LSB +: 2]);
      end
      if (hit_irqmask) begin
        irq_mask_q <= I_PWDATA[2:0];
      end
      if (hit_c0ctrl) begin
        cnt0_mode_q <= I_PWDATA[`DQIC_C0_STOP] ? COUNTER_OP_MODE_ONE : dqic_to_mode(I_PWDATA[2:0]);
        cnt0_ext_q <= I_PWDATA[`DQIC_C0_EXT];
      end
    end
  end

  // Sticky pending bits: held until a one is written; a set in the clear cycle wins
  always_ff @(posedge I_SYS_CLK or posedge I_RST) begin
    if (I_RST) begin
      irq_status_q <= 3'h0;
    end else begin
      irq_status_q <= (irq_status_q & ~irq_clr) | irq_set;
    end
  end

  // A code of 3 reads as a selected source but has no event, so it never raises
  assign O_FIRST_IRQ_LINE = irq_status_q[`DQIC_IRQ_FIRST] &&
                            (first_irq_source_select_q != SRC_OFF);
  assign O_SECOND_IRQ_LINE = irq_status_q[`DQIC_IRQ_SECOND] &&
                             (second_irq_source_select_q != SRC_OFF);
  assign O_IRQ = |(irq_status_q & irq_mask_q);

  // Read mux, captured in the setup phase so the bus sees a flop
  logic [31:0] rd_mux;
  always_comb begin
    rd_mux = 32'h0000_0000;
    case (1'b1)
      hit_res16: rd_mux = {16'h0000, fifo_head.data};
      hit_res32: rd_mux = {11'h000, fifo_head.chan, fifo_head.data};
      hit_adstat: begin
        rd_mux[`DQIC_ST_EMPTY] = fifo_empty_flag;
        rd_mux[`DQIC_ST_HALF] = fifo_half_full_flag;
        rd_mux[`DQIC_ST_FULL] = fifo_full_flag;
        rd_mux[`DQIC_ST_BUSY] = conversion_busy_flag_q;
      end
      hit_adctrl: rd_mux[`DQIC_CTL_PACER] = pacer_mode_q;
      hit_irqsel: begin
        rd_mux[`DQIC_SEL_FIRST_LSB +: 2] = first_irq_source_select_q;
        rd_mux[`DQIC_SEL_SECOND_LSB +: 2] = second_irq_source_select_q;
      end
      hit_irqstat: rd_mux[2:0] = irq_status_q;
      hit_irqmask: rd_mux[2:0] = irq_mask_q;
      hit_c0ctrl: rd_mux[3:0] = {cnt0_ext_q, cnt0_mode_q};
      hit_c0val: rd_mux[15:0] = cnt0_if.count;
      hit_pacer1: rd_mux[15:0] = div1_if.count;
      hit_pacer2: rd_mux[15:0] = div2_if.count;
      default: rd_mux = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge I_SYS_CLK or posedge I_RST) begin
    if (I_RST) begin
      prdata_q <= 32'h0000_0000;
    end else if (setup_ph && !I_PWRITE) begin
      prdata_q <= rd_mux; // Reading the count leaves the counter untouched
    end
  end
endmodule : dqic_top

//--- verif/dqic_conv_model.sv
// Behavioural converter model that answers the block's start pulses
module dqic_conv_model (
  input wire logic i_clk,
  input wire logic i_start,
  input wire logic [15:0] i_data,
  input wire logic [4:0] i_ch,
  input wire logic [3:0] i_lag,
  output logic o_done,
  output logic [15:0] o_data,
  output logic [4:0] o_ch
);
  timeunit 1ns;
  timeprecision 1ps;
  // One conversion per start; lag varies the answer time
  initial begin
    o_done = 1'b0;
    o_data = 16'hFFFF;
    o_ch = 5'h1F;
    forever begin
      @(posedge i_clk);
      if (i_start === 1'b1) begin
        repeat (i_lag) @(posedge i_clk);
        o_data <= i_data;
        o_ch <= i_ch;
        // Data settles three clocks ahead of ready
        repeat (3) @(posedge i_clk);
        o_done <= 1'b1;
        repeat (4) @(posedge i_clk);
        o_done <= 1'b0;
        // Released lines show the inverse, not the old sample
        o_data <= ~i_data;
        o_ch <= ~i_ch;
      end
    end
  end
endmodule : dqic_conv_model

//--- verif/dqic_top_chk.sv
// Port-level assertions for the acquisition control block
module dqic_top_chk (
  input wire logic I_SYS_CLK,
  input wire logic I_RST,
  input wire logic I_PSEL,
  input wire logic I_PENABLE,
  input wire logic I_PWRITE,
  input wire dqic_pkg::dqic_addr_t I_PADDR,
  input wire logic [31:0] I_PWDATA,
  input wire logic O_PREADY,
  input wire logic O_PSLVERR,
  input wire logic O_CONV_START,
  input wire logic O_CNT0_OUT,
  input wire logic O_PACER_TICK,
  input wire logic O_FIRST_IRQ_LINE,
  input wire logic O_SECOND_IRQ_LINE,
  input wire logic O_IRQ
);
  timeunit 1ns;
  timeprecision 1ps;
  import dqic_pkg::*;
  // Bus decode shadowing the written selects, mask and dividers
  wire acc_w = I_PSEL & I_PENABLE;
  wire wr_w = acc_w & I_PWRITE;
  wire sel_w = wr_w & (I_PADDR == 8'h10);
  wire clr1_w = wr_w & (I_PADDR == 8'h14) & I_PWDATA[0];
  wire clr2_w = wr_w & (I_PADDR == 8'h14) & I_PWDATA[1];
  wire ctl_w = wr_w & (I_PADDR == 8'h1C);
  wire c0w_w = ctl_w | (wr_w & (I_PADDR == 8'h20));
  wire unm_w = (I_PADDR[1:0] != 2'h0) | (I_PADDR > 8'h28);
  logic [3:0] sel_q;
  logic [2:0] mask_q;
  logic stop_q;
  logic [1:0] pz_q;
  // Shadow copies only; the design's own state stays hidden
  always_ff @(posedge I_SYS_CLK or posedge I_RST) begin
    if (I_RST) begin
      sel_q <= 4'h0;
      mask_q <= 3'h0;
      stop_q <= 1'b0;
      pz_q <= 2'b00;
    end else begin
      if (sel_w) sel_q <= {I_PWDATA[5:4], I_PWDATA[1:0]};
      if (wr_w && I_PADDR == 8'h18) mask_q <= I_PWDATA[2:0];
      if (c0w_w) stop_q <= ctl_w & I_PWDATA[4];
      if (wr_w && I_PADDR == 8'h24) pz_q[0] <= (I_PWDATA[15:0] == 16'h0000);
      if (wr_w && I_PADDR == 8'h28) pz_q[1] <= (I_PWDATA[15:0] == 16'h0000);
    end
  end
  default clocking cb @(posedge I_SYS_CLK); endclocking
  default disable iff (I_RST);
  sequence s_stop_req; ctl_w && I_PWDATA[4]; endsequence
  sequence s_out_high; ##[1:4] O_CNT0_OUT; endsequence
  property p_stop; s_stop_req |-> s_out_high; endproperty
  property p_stop_stay; stop_q && O_CNT0_OUT && !c0w_w |=> O_CNT0_OUT; endproperty
  property p_line1_off; sel_q[1:0] == 2'h0 |-> !O_FIRST_IRQ_LINE; endproperty
  property p_line2_off; sel_q[3:2] == 2'h0 |-> !O_SECOND_IRQ_LINE; endproperty
  property p_line1_hold; O_FIRST_IRQ_LINE && !sel_w && !clr1_w |=> O_FIRST_IRQ_LINE; endproperty
  property p_line2_hold; O_SECOND_IRQ_LINE && !sel_w && !clr2_w |=> O_SECOND_IRQ_LINE; endproperty
  property p_irq_mask; O_IRQ |-> mask_q != 3'h0; endproperty
  property p_pacer_zero; (|pz_q) && ($past(pz_q) != 2'b00) |-> !O_PACER_TICK; endproperty
  property p_start_gap; O_CONV_START |=> !O_CONV_START [*4]; endproperty
  property p_apb; acc_w |-> O_PREADY && (O_PSLVERR == unm_w); endproperty
  a_stop: assert property (p_stop) else $error("counter not high after stop");
  a_stop_stay: assert property (p_stop_stay) else $error("stopped output fell");
  a_line1_off: assert property (p_line1_off) else $error("first line active while off");
  a_line2_off: assert property (p_line2_off) else $error("second line active while off");
  a_line1_hold: assert property (p_line1_hold) else $error("first line dropped uncleared");
  a_line2_hold: assert property (p_line2_hold) else $error("second line dropped uncleared");
  a_irq_mask: assert property (p_irq_mask) else $error("irq high with all masked");
  a_pacer_zero: assert property (p_pacer_zero) else $error("pacer ticked with zero divider");
  a_start_gap: assert property (p_start_gap) else $error("start pulses too close");
  a_apb: assert property (p_apb) else $error("bad ready or error response");
endmodule : dqic_top_chk

bind dqic_top dqic_top_chk chk_u (.I_SYS_CLK(I_SYS_CLK), .I_RST(I_RST), .I_PSEL(I_PSEL),
  .I_PENABLE(I_PENABLE), .I_PWRITE(I_PWRITE), .I_PADDR(I_PADDR), .I_PWDATA(I_PWDATA),
  .O_PREADY(O_PREADY), .O_PSLVERR(O_PSLVERR), .O_CONV_START(O_CONV_START),
  .O_CNT0_OUT(O_CNT0_OUT), .O_PACER_TICK(O_PACER_TICK), .O_FIRST_IRQ_LINE(O_FIRST_IRQ_LINE),
  .O_SECOND_IRQ_LINE(O_SECOND_IRQ_LINE), .O_IRQ(O_IRQ));

//--- verif/tb_top.sv
// Self-checking bench for the acquisition control block
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int DEPTH = 16;
  logic clk, rst, psel, penable, pwrite, ext_clk, ext_irq, rerr, pready, pslverr;
  logic start, cnt0_out, tick, line1, line2, irq, done;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rdat, v1;
  logic [15:0] cdata, nx_data;
  logic [4:0] cch, nx_ch;
  logic [3:0] lag;
  logic [20:0] exp_q[$];
  logic [20:0] e;
  int failures, tests_run, n;
  // Small FIFO keeps the fill and overrun runs short
  dqic_top #(.FIFO_DEPTH(DEPTH), .FIFO_BLOCK(8)) dut_u (.I_SYS_CLK(clk), .I_RST(rst),
    .I_PSEL(psel), .I_PENABLE(penable), .I_PWRITE(pwrite), .I_PADDR(paddr), .I_PWDATA(pwdata),
    .O_PRDATA(prdata), .O_PREADY(pready), .O_PSLVERR(pslverr), .I_CONV_DONE(done),
    .I_CONV_DATA(cdata), .I_CONV_CH(cch), .O_CONV_START(start), .I_EXT_CLK(ext_clk),
    .I_EXT_IRQ(ext_irq), .O_CNT0_OUT(cnt0_out), .O_PACER_TICK(tick),
    .O_FIRST_IRQ_LINE(line1), .O_SECOND_IRQ_LINE(line2), .O_IRQ(irq));
  dqic_conv_model conv_u (.i_clk(clk), .i_start(start), .i_data(nx_data), .i_ch(nx_ch),
    .i_lag(lag), .o_done(done), .o_data(cdata), .o_ch(cch));
  // 40 MHz clock
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      failures++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  // One APB transfer; request held until ready is sampled
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
    end while (pready !== 1'b1);
    rdat = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask : wr
  task automatic rd(input logic [7:0] a);
    apb(1'b0, a, 32'h0000_0000);
  endtask : rd
  // Soft trigger one random sample, then poll busy under a bound
  task automatic conv();
    int k;
    logic [15:0] d;
    logic [4:0] c;
    k = 0;
    d = 16'($urandom);
    c = 5'($urandom);
    nx_data <= d;
    nx_ch <= c;
    lag <= 4'($urandom_range(5, 0));
    if (exp_q.size() < DEPTH) exp_q.push_back({c, d});
    wr(8'h0C, 32'h0000_0002);
    do begin
      rd(8'h08);
      k++;
    end while (rdat[3] !== 1'b0 && k < 40);
    chk("busy", 32'(rdat[3]), 32'h0);
    @(negedge clk);
  endtask : conv
  task automatic ticks(input int len);
    n = 0;
    repeat (len) begin
      @(negedge clk);
      if (tick === 1'b1) n++;
    end
  endtask : ticks
  task automatic wrap_up();
    $display("comparisons %0d mismatches %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : wrap_up
  // Hang guard, well above the expected run length
  initial begin
    repeat (20000) @(posedge clk);
    failures++;
    $display("watchdog expired");
    wrap_up();
  end
  initial begin
    {psel, penable, pwrite, ext_clk, ext_irq} = 5'h00;
    paddr = 8'h00;
    pwdata = 32'h0000_0000;
    nx_data = 16'h0000;
    nx_ch = 5'h00;
    lag = 4'h0;
    rst = 1'b1;
    failures = 0;
    tests_run = 0;
    void'($urandom(33));
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    rd(8'h18);
    chk("mask_rst", rdat, 32'h0);
    rd(8'h08);
    chk("stat_rst", rdat, 32'h1);
    chk("out_rst", 32'(cnt0_out), 32'h1);
    rd(8'h3C);
    chk("unm_err", 32'(rerr), 32'h1);
    chk("unm_data", rdat, 32'h0);
    // End-of-conversion event, a second event while pending, then mask and clear
    wr(8'h10, 32'h0000_0001);
    conv();
    chk("line1_eoc", 32'(line1), 32'h1);
    rd(8'h14);
    chk("pend", rdat, 32'h1);
    conv();
    chk("line1_held", 32'(line1), 32'h1);
    e = exp_q.pop_front();
    rd(8'h04);
    chk("res32", rdat, {11'h000, e});
    e = exp_q.pop_front();
    rd(8'h00);
    chk("res16", rdat, {16'h0000, e[15:0]});
    wr(8'h18, 32'h1);
    @(negedge clk);
    chk("irq_on", 32'(irq), 32'h1);
    wr(8'h18, 32'h0);
    @(negedge clk);
    chk("irq_off", 32'(irq), 32'h0);
    wr(8'h14, 32'h1);
    @(negedge clk);
    chk("line1_clr", 32'(line1), 32'h0);
    // Fill to half, full and overrun, then drain through the 16-bit word
    wr(8'h10, 32'h0000_0002);
    for (int i = 1; i <= DEPTH + 1; i++) begin
      conv();
      chk("line1_half", 32'(line1), 32'(i >= 8));
      rd(8'h08);
      chk("half", 32'(rdat[1]), 32'(i >= 8));
      chk("full", 32'(rdat[2]), 32'(i >= DEPTH));
    end
    rd(8'h14);
    chk("overrun", 32'(rdat[2]), 32'h1);
    while (exp_q.size() > 0) begin
      e = exp_q.pop_front();
      rd(8'h00);
      chk("drain", rdat, {16'h0000, e[15:0]});
    end
    rd(8'h08);
    chk("empty", 32'(rdat[0]), 32'h1);
    wr(8'h14, 32'h7);
    // Second line: external source, off, pacer, zero divider
    wr(8'h10, 32'h0000_0020);
    ext_irq <= 1'b1;
    repeat (6) @(posedge clk);
    ext_irq <= 1'b0;
    @(negedge clk);
    chk("line2_ext", 32'(line2), 32'h1);
    wr(8'h10, 32'h0);
    @(negedge clk);
    chk("line2_off", 32'(line2), 32'h0);
    wr(8'h14, 32'h2);
    wr(8'h24, 32'h2);
    wr(8'h28, 32'h3);
    wr(8'h10, 32'h0000_0010);
    repeat (20) @(posedge clk);
    ticks(60);
    chk("pacer_rate", 32'(n), 32'd10);
    chk("line2_tick", 32'(line2), 32'h1);
    // Pacer-triggered conversions land in the empty FIFO; then clear it
    wr(8'h0C, 32'h1);
    repeat (40) @(posedge clk);
    rd(8'h00);
    chk("pacer_conv", rdat, {16'h0000, nx_data});
    wr(8'h0C, 32'h4);
    wr(8'h24, 32'h0);
    repeat (2) @(posedge clk);
    wr(8'h14, 32'h2);
    ticks(30);
    chk("pacer_stop", 32'(n), 32'h0);
    chk("line2_clr", 32'(line2), 32'h0);
    // Counter 0: every mode, read-back while running, external events, stop
    for (int m = 0; m < 6; m++) begin
      wr(8'h1C, 32'(m));
      rd(8'h1C);
      chk("mode", 32'(rdat[2:0]), 32'(m));
    end
    wr(8'h1C, 32'h0);
    wr(8'h20, 32'd40);
    @(negedge clk);
    chk("out_low", 32'(cnt0_out), 32'h0);
    rd(8'h20);
    v1 = rdat;
    rd(8'h20);
    chk("count_run", rdat, v1 - 32'd3);
    repeat (50) @(posedge clk);
    @(negedge clk);
    chk("out_high", 32'(cnt0_out), 32'h1);
    wr(8'h1C, 32'h8);
    wr(8'h20, 32'd20);
    rd(8'h20);
    v1 = rdat;
    repeat (10) @(posedge clk);
    rd(8'h20);
    chk("ext_idle", rdat, v1);
    repeat (5) begin
      ext_clk <= 1'b1;
      repeat (3) @(posedge clk);
      ext_clk <= 1'b0;
      repeat (3) @(posedge clk);
    end
    repeat (4) @(posedge clk);
    rd(8'h20);
    chk("ext_count", rdat, v1 - 32'd5);
    wr(8'h1C, 32'h10);
    repeat (4) @(posedge clk);
    @(negedge clk);
    chk("stop_out", 32'(cnt0_out), 32'h1);
    rd(8'h1C);
    chk("stop_mode", 32'(rdat[2:0]), 32'h1);
    rd(8'h20);
    chk("stop_count", rdat, 32'h0);
    wrap_up();
  end
endmodule : tb_top
